// >>> wdt_pkg.sv
// Constants shared by the windowed watchdog block.
// Assumes a 32-bit APB register port and an 8-bit byte address.
`default_nettype none

package wdt_pkg;

  // Register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  localparam logic [7:0] SVC_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS = 8'h14;
  localparam logic [7:0] CFG_OFS = 8'h18;
  localparam logic [7:0] CNT_OFS = 8'h1c;

  // Control register fields
  localparam int CTRL_WIN_BIT = 7;
  localparam int CTRL_FRZ_BIT = 6;
  localparam int CTRL_RATE_MSB = 2;
  localparam int RATE_W = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status and mask fields
  localparam int ST_W = 2;
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_EARLY_BIT = 1;
  localparam logic [1:0] ST_RESET = 2'h0;

  // Configuration fields
  localparam int CFG_PSR_BIT = 0;
  localparam logic CFG_PSR_RESET = 1'b0;

  // Service values
  localparam logic [7:0] SVC_ARM = 8'h55;
  localparam logic [7:0] SVC_FIRE = 8'haa;

  // Counter geometry and time-out exponents per rate code
  localparam int CNT_W = 25;
  localparam int EXP_W = 5;
  localparam logic [7:0][4:0] RATE_EXP_DEF = {5'h18, 5'h17, 5'h16, 5'h14, 5'h12, 5'h10, 5'h0e, 5'h00};

  typedef enum logic {
    SVC_IDLE = 1'b0,
    SVC_ARMED = 1'b1
  } wdt_svc_type;

endpackage

`default_nettype wire

// >>> wdt_cnt_if.sv
// Link between the watchdog register logic and its period counter.
// Assumes both ends share pclk.
`timescale 1ns/10ps
`default_nettype none

interface wdt_cnt_if;
  logic enable;
  logic [wdt_pkg::EXP_W-1:0] exp;
  logic freeze;
  logic restart;
  logic [wdt_pkg::CNT_W-1:0] count;
  logic timeout;
  logic window_open;
  modport ctrl (output enable, output exp, output freeze, output restart,
                input count, input timeout, input window_open);
  modport cnt (input enable, input exp, input freeze, input restart,
               output count, output timeout, output window_open);
endinterface

`default_nettype wire

// >>> wdt_counter.sv
// Watchdog period counter with time-out pulse and window flag.
// Assumes exp is at least 2 while enabled.
`timescale 1ns/10ps
`default_nettype none

module wdt_counter (
  input wire logic pclk,
  input wire logic presetn,
  wdt_cnt_if.cnt cif
);
  localparam int CW = wdt_pkg::CNT_W;

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic to_r;
  logic to_nxt;
  logic [CW-1:0] last;
  logic [CW-1:0] win_start;

  always_comb begin
    last = CW'((CW'(1) << cif.exp) - CW'(1));
    win_start = CW'(CW'(3) << (cif.exp - 5'h2));
    count_nxt = count_r;
    to_nxt = 1'b0;
    if (!cif.enable || cif.restart) begin
      count_nxt = '0;
    end else if (!cif.freeze) begin
      if (count_r == last) begin
        count_nxt = '0;
        to_nxt = 1'b1;
      end else begin
        count_nxt = CW'(count_r + CW'(1));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
      to_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      to_r <= to_nxt;
    end
  end

  assign cif.count = count_r;
  assign cif.timeout = to_r;
  // Last quarter of the period
  assign cif.window_open = (count_r >= win_start);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_freeze_hold;
    cif.enable && cif.freeze && !cif.restart |=> $stable(count_r);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("Counter moved while frozen");

  property p_disabled_zero;
    !cif.enable |=> count_r == '0 && !to_r;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("Disabled counter not cleared");

  property p_timeout_at_end;
    cif.enable && !cif.freeze && !cif.restart && count_r == last |=> to_r && count_r == '0 ##1 !to_r;
  endproperty
  a_timeout_at_end: assert property (p_timeout_at_end) else $error("No time-out at end of period");

endmodule

`default_nettype wire

// >>> wdt_top.sv
// Windowed watchdog: APB registers, service sequence, reset request.
// Assumes pclk is the oscillator clock; mode inputs synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none

module wdt_top #(
  parameter logic [7:0][4:0] RATE_EXP = wdt_pkg::RATE_EXP_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic debug_active,
  input wire logic pseudo_stop,
  output logic sys_reset_req,
  output logic tick_freeze,
  output logic irq
);
  localparam int SW = wdt_pkg::ST_W;

  wdt_cnt_if cnt_if();

  wdt_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cnt_if.cnt)
  );

  logic win_r;
  logic win_nxt;
  logic frz_r;
  logic frz_nxt;
  logic [wdt_pkg::RATE_W-1:0] rate_r;
  logic [wdt_pkg::RATE_W-1:0] rate_nxt;
  logic ctl_lock_r;
  logic ctl_lock_nxt;
  logic frz_lock_r;
  logic frz_lock_nxt;
  logic psr_r;
  logic psr_nxt;
  logic [SW-1:0] status_r;
  logic [SW-1:0] status_nxt;
  logic [SW-1:0] mask_r;
  logic [SW-1:0] mask_nxt;
  wdt_pkg::wdt_svc_type svc_r;
  wdt_pkg::wdt_svc_type svc_nxt;
  logic rst_req_r;
  logic rst_req_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  logic wr;
  logic wr_ctl;
  logic wr_svc;
  logic addr_hit;
  logic enabled;
  logic ctl_accept;
  logic early;
  logic restart_svc;
  logic restart_ctl;
  logic [7:0] wbyte;
  logic [SW-1:0] events;

  // Bus decode
  always_comb begin
    case (paddr)
      wdt_pkg::CTRL_OFS, wdt_pkg::SVC_OFS, wdt_pkg::STAT_OFS,
      wdt_pkg::MASK_OFS, wdt_pkg::CFG_OFS, wdt_pkg::CNT_OFS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign wr = psel && penable && pwrite && addr_hit;
  assign wr_ctl = wr && (paddr == wdt_pkg::CTRL_OFS);
  assign wr_svc = wr && (paddr == wdt_pkg::SVC_OFS);
  assign wbyte = pwdata[7:0];
  assign enabled = (rate_r != '0);
  assign ctl_accept = special_mode || !ctl_lock_r;

  // Control and configuration
  always_comb begin
    win_nxt = win_r;
    rate_nxt = rate_r;
    ctl_lock_nxt = ctl_lock_r;
    frz_nxt = frz_r;
    frz_lock_nxt = frz_lock_r;
    psr_nxt = psr_r;
    mask_nxt = mask_r;
    restart_ctl = 1'b0;
    if (wr_ctl && ctl_accept) begin
      win_nxt = pwdata[wdt_pkg::CTRL_WIN_BIT];
      rate_nxt = pwdata[wdt_pkg::CTRL_RATE_MSB:0];
      if (!special_mode) begin
        ctl_lock_nxt = 1'b1;
      end
      if (pwdata[wdt_pkg::CTRL_RATE_MSB:0] != '0) begin
        restart_ctl = 1'b1;
      end
    end
    if (wr_ctl && !frz_lock_r) begin
      frz_nxt = pwdata[wdt_pkg::CTRL_FRZ_BIT];
      frz_lock_nxt = 1'b1;
    end
    if (wr && (paddr == wdt_pkg::CFG_OFS)) begin
      psr_nxt = pwdata[wdt_pkg::CFG_PSR_BIT];
    end
    if (wr && (paddr == wdt_pkg::MASK_OFS)) begin
      mask_nxt = pwdata[SW-1:0];
    end
  end

  // Service sequence
  always_comb begin
    svc_nxt = svc_r;
    early = 1'b0;
    restart_svc = 1'b0;
    if (wr_svc && enabled) begin
      if (win_r && !cnt_if.window_open && (wbyte == wdt_pkg::SVC_ARM || wbyte == wdt_pkg::SVC_FIRE)) begin
        early = 1'b1;
        svc_nxt = wdt_pkg::SVC_IDLE;
      end else if (wbyte == wdt_pkg::SVC_ARM) begin
        svc_nxt = wdt_pkg::SVC_ARMED;
      end else if (wbyte == wdt_pkg::SVC_FIRE && svc_r == wdt_pkg::SVC_ARMED) begin
        restart_svc = 1'b1;
        svc_nxt = wdt_pkg::SVC_IDLE;
      end else begin
        svc_nxt = wdt_pkg::SVC_IDLE;
      end
    end
    if (!enabled) begin
      svc_nxt = wdt_pkg::SVC_IDLE;
    end
  end

  // Events, status, interrupt and reset pulse
  always_comb begin
    events = '0;
    events[wdt_pkg::ST_TIMEOUT_BIT] = cnt_if.timeout;
    events[wdt_pkg::ST_EARLY_BIT] = early;
    status_nxt = status_r;
    if (wr && (paddr == wdt_pkg::STAT_OFS)) begin
      status_nxt = status_r & ~pwdata[SW-1:0];
    end
    // Set wins over a clear in the same cycle
    status_nxt = status_nxt | events;
    irq_nxt = |(status_nxt & mask_nxt);
    rst_req_nxt = cnt_if.timeout || early;
  end

  // Read data captured in the setup cycle
  always_comb begin
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      prdata_nxt = '0;
      case (paddr)
        wdt_pkg::CTRL_OFS: begin
          prdata_nxt[wdt_pkg::CTRL_WIN_BIT] = win_r;
          prdata_nxt[wdt_pkg::CTRL_FRZ_BIT] = frz_r;
          prdata_nxt[wdt_pkg::CTRL_RATE_MSB:0] = rate_r;
        end
        wdt_pkg::SVC_OFS: prdata_nxt[0] = (svc_r == wdt_pkg::SVC_ARMED);
        wdt_pkg::STAT_OFS: prdata_nxt[SW-1:0] = status_r;
        wdt_pkg::MASK_OFS: prdata_nxt[SW-1:0] = mask_r;
        wdt_pkg::CFG_OFS: prdata_nxt[wdt_pkg::CFG_PSR_BIT] = psr_r;
        wdt_pkg::CNT_OFS: prdata_nxt[wdt_pkg::CNT_W-1:0] = cnt_if.count;
        default: prdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_r <= wdt_pkg::CTRL_RESET[wdt_pkg::CTRL_WIN_BIT];
      frz_r <= wdt_pkg::CTRL_RESET[wdt_pkg::CTRL_FRZ_BIT];
      rate_r <= wdt_pkg::CTRL_RESET[wdt_pkg::CTRL_RATE_MSB:0];
      ctl_lock_r <= 1'b0;
      frz_lock_r <= 1'b0;
      psr_r <= wdt_pkg::CFG_PSR_RESET;
      status_r <= wdt_pkg::ST_RESET;
      mask_r <= wdt_pkg::ST_RESET;
      svc_r <= wdt_pkg::SVC_IDLE;
      rst_req_r <= 1'b0;
      irq_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      win_r <= win_nxt;
      frz_r <= frz_nxt;
      rate_r <= rate_nxt;
      ctl_lock_r <= ctl_lock_nxt;
      frz_lock_r <= frz_lock_nxt;
      psr_r <= psr_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      svc_r <= svc_nxt;
      rst_req_r <= rst_req_nxt;
      irq_r <= irq_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Counter steering
  assign cnt_if.enable = enabled;
  assign cnt_if.exp = RATE_EXP[rate_r];
  assign cnt_if.restart = restart_svc || restart_ctl;
  assign cnt_if.freeze = (frz_r && debug_active) || (pseudo_stop && !psr_r);
  assign tick_freeze = frz_r && debug_active;

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign sys_reset_req = rst_req_r;
  assign irq = irq_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ctl_locked;
    wr_ctl && ctl_lock_r && !special_mode |=> $stable(rate_r) && $stable(win_r);
  endproperty
  a_ctl_locked: assert property (p_ctl_locked) else $error("Locked control field changed");

  property p_frz_once;
    wr_ctl && frz_lock_r |=> $stable(frz_r);
  endproperty
  a_frz_once: assert property (p_frz_once) else $error("Debug freeze bit written twice");

  property p_early_reset;
    wr_svc && enabled && win_r && !cnt_if.window_open && (wbyte == wdt_pkg::SVC_ARM)
      |=> sys_reset_req && status_r[wdt_pkg::ST_EARLY_BIT];
  endproperty
  a_early_reset: assert property (p_early_reset) else $error("Early service did not reset");

  property p_arm_in_window;
    wr_svc && enabled && cnt_if.window_open && wbyte == wdt_pkg::SVC_ARM && !cnt_if.timeout
      |=> !sys_reset_req && svc_r == wdt_pkg::SVC_ARMED;
  endproperty
  a_arm_in_window: assert property (p_arm_in_window) else $error("Service in window penalised");

  property p_fire_restart;
    wr_svc && enabled && !early && svc_r == wdt_pkg::SVC_ARMED && wbyte == wdt_pkg::SVC_FIRE
      |=> cnt_if.count == '0 && svc_r == wdt_pkg::SVC_IDLE;
  endproperty
  a_fire_restart: assert property (p_fire_restart) else $error("Service sequence did not restart");

  property p_rate_start;
    wr_ctl && ctl_accept && pwdata[wdt_pkg::CTRL_RATE_MSB:0] != '0
      |=> rate_r == $past(pwdata[wdt_pkg::CTRL_RATE_MSB:0]) && cnt_if.enable && cnt_if.count == '0;
  endproperty
  a_rate_start: assert property (p_rate_start) else $error("Nonzero rate did not start counter");

  property p_timeout_reset;
    cnt_if.timeout |=> sys_reset_req && status_r[wdt_pkg::ST_TIMEOUT_BIT];
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("Time-out gave no reset request");

  property p_reset_pulse;
    sys_reset_req && !$past(early) && !cnt_if.timeout && !early |=> !sys_reset_req;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("Reset request longer than a cycle");

  property p_debug_freeze;
    frz_r && debug_active && enabled && !cnt_if.restart |-> tick_freeze ##1 $stable(cnt_if.count);
  endproperty
  a_debug_freeze: assert property (p_debug_freeze) else $error("Debug freeze not applied");

endmodule

`default_nettype wire

// >>> tb_windowed_watchdog_timer.sv
// Self-checking bench for the windowed watchdog: APB master, reset pulse monitor, scenarios.
// Assumes wdt_top with a shortened rate table (period 2^(code+2) cycles).
`timescale 1ns/10ps
`default_nettype none

module tb_windowed_watchdog_timer;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic special_mode = 1'b1;
  logic debug_active = 1'b0;
  logic pseudo_stop = 1'b0;
  logic [31:0] prdata, rd, c0;
  logic pready, pslverr, er, sys_reset_req, tick_freeze, irq;
  logic prev = 1'b0;
  logic [31:0] seed = 32'h0000_d7e1;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int n_pulse = 0;
  int last = 0;
  int gap = 0;
  int n0, d;

  initial begin
    forever #2 pclk = ~pclk;
  end

  wdt_top #(.RATE_EXP({5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h00})) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode(special_mode), .debug_active(debug_active), .pseudo_stop(pseudo_stop),
    .sys_reset_req(sys_reset_req), .tick_freeze(tick_freeze), .irq(irq));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic rnd(input int m);
    seed = xs(seed);
    d = int'(seed % m);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Setup, access, wait for pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wait_p(input int n);
    while (n_pulse < n) @(posedge pclk);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Pulse counting, width and spacing
  always @(posedge pclk) begin
    cyc++;
    if (sys_reset_req === 1'b1) begin
      chk("pulse_width", 32'h0, {31'h0, prev});
      n_pulse++;
      gap = cyc - last;
      last = cyc;
    end
    prev = sys_reset_req;
    if (cyc > 30000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    do_reset();
    rdc("ctrl_rst", wdt_pkg::CTRL_OFS, 32'h0000_0000);
    rdc("stat_rst", wdt_pkg::STAT_OFS, 32'h0000_0000);
    rdc("mask_rst", wdt_pkg::MASK_OFS, 32'h0000_0000);
    rdc("cfg_rst", wdt_pkg::CFG_OFS, 32'h0000_0000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
    // First control write also fixes the freeze bit
    wr(wdt_pkg::CTRL_OFS, 32'h0000_0041);
    rdc("ctrl_wr", wdt_pkg::CTRL_OFS, 32'h0000_0041);
    wait_p(2);
    chk("gap_code1", 32'd8, gap);
    debug_active <= 1'b1;
    idle(4);
    chk("tick_freeze", 32'h1, {31'h0, tick_freeze});
    n0 = n_pulse;
    idle(40);
    chk("debug_hold", n0, n_pulse);
    debug_active <= 1'b0;
    idle(20);
    chk("debug_run", 32'h1, {31'h0, n_pulse > n0});
    chk("tick_run", 32'h0, {31'h0, tick_freeze});
    pseudo_stop <= 1'b1;
    idle(4);
    n0 = n_pulse;
    apb(1'b0, wdt_pkg::CNT_OFS, 32'h0000_0000);
    c0 = rd;
    idle(20);
    rdc("pstop_cnt", wdt_pkg::CNT_OFS, c0);
    chk("pstop_hold", n0, n_pulse);
    wr(wdt_pkg::CFG_OFS, 32'h0000_0001);
    idle(20);
    chk("pstop_run", 32'h1, {31'h0, n_pulse > n0});
    pseudo_stop <= 1'b0;
    apb(1'b0, wdt_pkg::STAT_OFS, 32'h0000_0000);
    chk("stat_timeout", 32'h1, {31'h0, rd[0]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(wdt_pkg::MASK_OFS, 32'h0000_0001);
    idle(2);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(wdt_pkg::CTRL_OFS, 32'h0000_0000);
    rdc("ctrl_frz_once", wdt_pkg::CTRL_OFS, 32'h0000_0040);
    idle(5);
    wr(wdt_pkg::STAT_OFS, 32'h0000_0003);
    idle(2);
    chk("irq_off", 32'h0, {31'h0, irq});
    n0 = n_pulse;
    idle(100);
    chk("rate0_off", n0, n_pulse);
    wr(wdt_pkg::MASK_OFS, xs(seed));
    rdc("mask_rw", wdt_pkg::MASK_OFS, xs(seed) & 32'h0000_0003);
    for (int c = 1; c < 8; c++) begin
      wr(wdt_pkg::CTRL_OFS, c);
      n0 = n_pulse;
      // A pulse already in flight at the rate change may come first
      wait_p(n0 + 3);
      chk("gap_code", 32'h1 << (c + 2), gap);
    end
    // Normal mode: early service is harmless
    wr(wdt_pkg::CTRL_OFS, 32'h0000_0004);
    n0 = n_pulse;
    for (int i = 0; i < 5; i++) begin
      rnd(40);
      idle(d);
      wr(wdt_pkg::SVC_OFS, 32'h0000_0055);
      wr(wdt_pkg::SVC_OFS, 32'h0000_00aa);
    end
    chk("normal_svc", n0, n_pulse);
    // Window mode: repeated first value, then restart, all late
    wr(wdt_pkg::CTRL_OFS, 32'h0000_0084);
    n0 = n_pulse;
    for (int i = 0; i < 4; i++) begin
      rnd(5);
      idle(47 + d);
      wr(wdt_pkg::SVC_OFS, 32'h0000_0055);
      wr(wdt_pkg::SVC_OFS, 32'h0000_0055);
      wr(wdt_pkg::SVC_OFS, 32'h0000_00aa);
    end
    chk("window_svc", n0, n_pulse);
    rnd(40);
    idle(d);
    wr(wdt_pkg::SVC_OFS, 32'h0000_0055);
    idle(3);
    chk("early_reset", n0 + 1, n_pulse);
    apb(1'b0, wdt_pkg::STAT_OFS, 32'h0000_0000);
    chk("stat_early", 32'h1, {31'h0, rd[1]});
    // Second reset while running, then user mode lock
    special_mode <= 1'b0;
    do_reset();
    rdc("ctrl_rst2", wdt_pkg::CTRL_OFS, 32'h0000_0000);
    wr(wdt_pkg::CTRL_OFS, 32'h0000_0001);
    wr(wdt_pkg::CTRL_OFS, 32'h0000_0086);
    rdc("ctrl_lock", wdt_pkg::CTRL_OFS, 32'h0000_0001);
    n0 = n_pulse;
    // Freeze bit clear: debug must not stop the counter
    debug_active <= 1'b1;
    wait_p(n0 + 2);
    chk("gap_locked", 32'd8, gap);
    chk("tick_clear", 32'h0, {31'h0, tick_freeze});
    stop_test();
  end
endmodule

`default_nettype wire
